/* verilog/tkc_map.svh */
// Constants for the touch key command interpreter.
// Assumes one 50 MHz clock and byte-wide command and reply streams.
// What this block does
// - Overview returns status, first key, counters
// - Report all keys as bit field
// - Setup dump halts scanning, returns area, CRC
// - Return last command byte received
// - Diagnostic commands return internal factory code
// - Sleep acknowledged with complement, no CRC
// - Asleep: wake on edge, scan once
// - Any other valid command cancels sleep
// - Signal and reference sent low byte first
// - CRC over command and data appended
// - Status bits: gain test, detect, limit
// - Status bits: calibrating, calibration failed
// - Calibration only in key's own timeslot
// - Calibration scheduled, acknowledged with complement
// - Sleep at scan end if idle, enabled
// - Key data: signal, reference, integrator count
// - Key status command, index 0 to 47
`ifndef TKC_MAP_SVH
`define TKC_MAP_SVH
`define TKC_CMD_OVW      8'h00
`define TKC_CMD_ALL      8'h07
`define TKC_CMD_ERR      8'h0B
`define TKC_CMD_DUMP     8'h0D
`define TKC_CMD_EECRC    8'h0E
`define TKC_CMD_LAST     8'h0F
`define TKC_CMD_DIAG_A   8'h10
`define TKC_CMD_DIAG_B   8'h13
`define TKC_CMD_SLEEP    8'h16
`define TKC_GRP_DATA     2'h1
`define TKC_GRP_STAT     2'h2
`define TKC_GRP_CAL      2'h3
`define TKC_NUM_KEYS     6'h30
`define TKC_LEN_OVW      9'h005
`define TKC_LEN_BITS     9'h006
`define TKC_LEN_ONE      9'h001
`define TKC_LEN_DATA     9'h005
`define TKC_LEN_SETUP    9'h15C
`define TKC_CRC_POLY     16'h1021
`define TKC_CRC_INIT     16'h0000
`define TKC_DIAG_CODE    8'h5A
`define TKC_CAL_WIN_NS   110000000
`define TKC_CLK_NS       20
`endif

/* verilog/tkc_pkg.sv */
// Types for the touch key command interpreter.
// Assumes nothing from tkc_map.svh; the state codes are one-hot literals.
package tkc_pkg;
	typedef enum logic [3:0]
	{
		TKC_IDLE   = 4'b0001,
		TKC_DATA   = 4'b0010,
		TKC_CRC_LO = 4'b0100,
		TKC_CRC_HI = 4'b1000
	} tkc_state_type;
	typedef enum logic [3:0]
	{
		TKC_C_OVW, TKC_C_ALL, TKC_C_ERR, TKC_C_DUMP, TKC_C_EECRC,
		TKC_C_ACK, TKC_C_DIAG, TKC_C_DATA, TKC_C_STAT
	} tkc_cls_type;
endpackage

/* verilog/tkc_cmd.sv */
// Host command interpreter of a 48-key matrix touch controller.
// Assumes framing is done outside: one byte per cmd_valid_i pulse.
`timescale 1ns/1ns
`default_nettype none
`include "tkc_map.svh"
module tkc_cmd #(
	parameter int CAL_WIN_CYC = `TKC_CAL_WIN_NS / `TKC_CLK_NS
)(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [7:0]  cmd_byte_i,
	input  wire logic        tx_ready_i,
	output logic             tx_valid_o,
	output logic [7:0]       tx_byte_o,
	output logic             busy_o,
	input  wire logic [7:0]  dev_status_i,
	input  wire logic [7:0]  first_key_i,
	input  wire logic [7:0]  cnt_100ms_i,
	input  wire logic [7:0]  cnt_scan_i,
	input  wire logic [7:0]  cnt_sigfail_i,
	input  wire logic [47:0] key_detect_i,
	input  wire logic [47:0] err_flags_i,
	input  wire logic [47:0] key_gain_safety_test_fail_i,
	input  wire logic [47:0] ref_below_lower_signal_limit_i,
	input  wire logic [47:0] key_calibrating_i,
	input  wire logic [47:0] key_cal_failed_i,
	output logic [5:0]       key_sel_o,
	input  wire logic [15:0] key_signal_i,
	input  wire logic [15:0] key_ref_i,
	input  wire logic [7:0]  normalized_integrator_count_i,
	output logic [8:0]       setup_addr_o,
	input  wire logic [7:0]  setup_data_i,
	input  wire logic [15:0] setup_crc_i,
	output logic             scan_halt_o,
	input  wire logic        slot_strobe_i,
	input  wire logic [5:0]  slot_key_i,
	output logic             cal_pending_o,
	output logic             cal_go_o,
	output logic [5:0]       cal_key_o,
	input  wire logic        scan_done_i,
	input  wire logic        key_active_i,
	input  wire logic        sleep_en_i,
	input  wire logic        host_int_i,
	output logic             sleep_o,
	output logic             scan_req_o
);
	////////////////////////////////////////////////////////////////////
	// Byte-wide CRC step, MSB first
	function automatic logic [15:0] crc_upd(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
		begin
			r = r[15] ? ((r << 1) ^ `TKC_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	tkc_pkg::tkc_state_type state_reg, state_next;
	tkc_pkg::tkc_cls_type   cls_reg;
	logic [8:0]  idx_reg, len_reg;
	logic [15:0] crc_reg;
	logic        setup_crc_reg, use_crc_reg;
	logic [7:0]  reply_reg, last_cmd_reg;
	logic [7:0]  tx_byte_reg;
	logic        tx_valid_reg;
	logic [5:0]  key_sel_reg, cal_key_reg;
	logic        cal_first_reg, cal_pending_reg, cal_go_reg;
	logic [7:0]  cal_first_cmd_reg;
	logic [22:0] cal_tmr_reg;
	logic        armed_reg, asleep_reg, scan_req_reg;
	logic        int_prev_reg, halt_reg, busy_reg;

	////////////////////////////////////////////////////////////////////
	// Command decode; indexed commands need k below 48
	wire [5:0] cmd_k   = cmd_byte_i[5:0];
	wire       k_ok    = cmd_k < `TKC_NUM_KEYS;
	wire [1:0] grp     = cmd_byte_i[7:6];
	wire       c_ovw   = cmd_byte_i == `TKC_CMD_OVW;
	wire       c_all   = cmd_byte_i == `TKC_CMD_ALL;
	wire       c_err   = cmd_byte_i == `TKC_CMD_ERR;
	wire       c_dump  = cmd_byte_i == `TKC_CMD_DUMP;
	wire       c_eecrc = cmd_byte_i == `TKC_CMD_EECRC;
	wire       c_last  = cmd_byte_i == `TKC_CMD_LAST;
	wire       c_diag  = (cmd_byte_i == `TKC_CMD_DIAG_A) ||
		(cmd_byte_i == `TKC_CMD_DIAG_B);
	wire       c_sleep = cmd_byte_i == `TKC_CMD_SLEEP;
	wire       c_data  = grp == `TKC_GRP_DATA && k_ok;
	wire       c_stat  = grp == `TKC_GRP_STAT && k_ok;
	wire       c_cal   = grp == `TKC_GRP_CAL && k_ok;
	wire       c_valid = c_ovw | c_all | c_err | c_dump | c_eecrc | c_last
		| c_diag | c_sleep | c_data | c_stat | c_cal;
	wire       idle    = state_reg == tkc_pkg::TKC_IDLE;
	wire       take    = cmd_valid_i && idle;
	// Second identical calibration byte inside the window schedules it
	wire       cal_sched = take && c_cal && cal_first_reg &&
		cal_first_cmd_reg == cmd_byte_i;
	wire       cal_win_out = cal_tmr_reg == 23'(CAL_WIN_CYC);
	wire       slot_free = !tx_valid_reg || tx_ready_i;

	////////////////////////////////////////////////////////////////////
	// Reply byte for the current index
	wire [2:0]  b  = idx_reg[2:0];
	wire [47:0] bits48 = (cls_reg == tkc_pkg::TKC_C_ALL) ? key_detect_i
		: err_flags_i;
	wire [7:0]  bits_byte = bits48[{b, 3'h0} +: 8];
	wire [7:0]  ovw_byte = (b == 3'h0) ? dev_status_i :
		(b == 3'h1) ? first_key_i : (b == 3'h2) ? cnt_100ms_i :
		(b == 3'h3) ? cnt_scan_i : cnt_sigfail_i;
	wire [7:0]  data_byte = (b == 3'h0) ? key_signal_i[7:0] :
		(b == 3'h1) ? key_signal_i[15:8] :
		(b == 3'h2) ? key_ref_i[7:0] :
		(b == 3'h3) ? key_ref_i[15:8] :
		normalized_integrator_count_i;
	wire [7:0]  stat_byte = {3'h0,
		key_gain_safety_test_fail_i[key_sel_reg],
		key_detect_i[key_sel_reg],
		ref_below_lower_signal_limit_i[key_sel_reg],
		key_calibrating_i[key_sel_reg],
		key_cal_failed_i[key_sel_reg]};
	logic [7:0] cur_byte;
	// Class selects the source of each data byte
	always_comb
	begin
		case (cls_reg)
			tkc_pkg::TKC_C_OVW:  cur_byte = ovw_byte;
			tkc_pkg::TKC_C_ALL,
			tkc_pkg::TKC_C_ERR:  cur_byte = bits_byte;
			tkc_pkg::TKC_C_DUMP: cur_byte = setup_data_i;
			tkc_pkg::TKC_C_DIAG: cur_byte = `TKC_DIAG_CODE;
			tkc_pkg::TKC_C_DATA: cur_byte = data_byte;
			tkc_pkg::TKC_C_STAT: cur_byte = stat_byte;
			default:             cur_byte = reply_reg;
		endcase
	end
	wire last_data = idx_reg == len_reg - 9'h001;
	wire [15:0] crc_out = setup_crc_reg ? setup_crc_i : crc_reg;

	////////////////////////////////////////////////////////////////////
	// Reply sequencer
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			tkc_pkg::TKC_IDLE:
				if (take && c_eecrc)
					state_next = tkc_pkg::TKC_CRC_LO;
				else if (take && c_valid && !(c_cal && !cal_sched))
					state_next = tkc_pkg::TKC_DATA;
			tkc_pkg::TKC_DATA:
				if (slot_free && last_data)
					state_next = use_crc_reg ? tkc_pkg::TKC_CRC_LO
						: tkc_pkg::TKC_IDLE;
			tkc_pkg::TKC_CRC_LO:
				if (slot_free)
					state_next = tkc_pkg::TKC_CRC_HI;
			tkc_pkg::TKC_CRC_HI:
				if (slot_free)
					state_next = tkc_pkg::TKC_IDLE;
			default:
				state_next = tkc_pkg::TKC_IDLE;
		endcase
	end

	// Command capture: class, length, reply byte and which CRC is sent
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			cls_reg       <= tkc_pkg::TKC_C_ACK;
			len_reg       <= `TKC_LEN_ONE;
			use_crc_reg   <= 1'b0;
			setup_crc_reg <= 1'b0;
			reply_reg     <= 8'h00;
			key_sel_reg   <= 6'h00;
		end
		else if (take)
		begin
			key_sel_reg   <= cmd_k;
			setup_crc_reg <= c_dump | c_eecrc;
			use_crc_reg   <= !(c_last | c_sleep | c_cal);
			reply_reg     <= c_last ? last_cmd_reg : ~cmd_byte_i;
			cls_reg <= c_ovw ? tkc_pkg::TKC_C_OVW : c_all ? tkc_pkg::TKC_C_ALL
				: c_err ? tkc_pkg::TKC_C_ERR : c_dump ? tkc_pkg::TKC_C_DUMP
				: c_eecrc ? tkc_pkg::TKC_C_EECRC : c_diag ? tkc_pkg::TKC_C_DIAG
				: c_data ? tkc_pkg::TKC_C_DATA : c_stat ? tkc_pkg::TKC_C_STAT
				: tkc_pkg::TKC_C_ACK;
			len_reg <= c_ovw ? `TKC_LEN_OVW : (c_all | c_err) ? `TKC_LEN_BITS
				: c_dump ? `TKC_LEN_SETUP : c_data ? `TKC_LEN_DATA
				: `TKC_LEN_ONE;
		end
	end

	// Byte output, index and running CRC
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			state_reg    <= tkc_pkg::TKC_IDLE;
			idx_reg      <= 9'h000;
			crc_reg      <= `TKC_CRC_INIT;
			tx_valid_reg <= 1'b0;
			tx_byte_reg  <= 8'h00;
			busy_reg     <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			// Same value as the state test, but busy_o now leaves a flop
			busy_reg  <= state_next != tkc_pkg::TKC_IDLE;
			if (take)
			begin
				idx_reg <= 9'h000;
				crc_reg <= crc_upd(`TKC_CRC_INIT, cmd_byte_i);
			end
			if (slot_free && !idle)
			begin
				tx_valid_reg <= 1'b1;
				if (state_reg == tkc_pkg::TKC_DATA)
				begin
					tx_byte_reg <= cur_byte;
					crc_reg     <= crc_upd(crc_reg, cur_byte);
					idx_reg     <= idx_reg + 9'h001;
				end
				else if (state_reg == tkc_pkg::TKC_CRC_LO)
					tx_byte_reg <= crc_out[7:0];
				else
					tx_byte_reg <= crc_out[15:8];
			end
			else if (tx_ready_i)
				tx_valid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Last byte seen, scan halt during the setup dump
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			last_cmd_reg <= 8'h00;
			halt_reg     <= 1'b0;
		end
		else
		begin
			if (cmd_valid_i)
				last_cmd_reg <= cmd_byte_i;
			if (take && c_dump)
				halt_reg <= 1'b1;
			else if (state_next == tkc_pkg::TKC_IDLE)
				halt_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Calibration: window timer, then wait for the key's timeslot
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			cal_first_reg     <= 1'b0;
			cal_first_cmd_reg <= 8'h00;
			cal_tmr_reg       <= 23'h000000;
			cal_pending_reg   <= 1'b0;
			cal_key_reg       <= 6'h00;
			cal_go_reg        <= 1'b0;
		end
		else
		begin
			cal_go_reg <= 1'b0;
			if (cal_sched)
			begin
				cal_first_reg   <= 1'b0;
				cal_pending_reg <= 1'b1;
				cal_key_reg     <= cmd_k;
			end
			else if (take)
			begin
				cal_first_reg     <= c_cal;
				cal_first_cmd_reg <= cmd_byte_i;
				cal_tmr_reg       <= 23'h000000;
			end
			else if (cal_first_reg)
			begin
				cal_tmr_reg <= cal_tmr_reg + 23'h000001;
				if (cal_win_out)
					cal_first_reg <= 1'b0;
			end
			if (cal_pending_reg && !cal_sched && slot_strobe_i &&
				slot_key_i == cal_key_reg)
			begin
				cal_pending_reg <= 1'b0;
				cal_go_reg      <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sleep: armed by command, entered at scan end when idle
	wire int_edge = host_int_i != int_prev_reg;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			armed_reg    <= 1'b0;
			asleep_reg   <= 1'b0;
			scan_req_reg <= 1'b0;
			int_prev_reg <= 1'b0;
		end
		else
		begin
			int_prev_reg <= host_int_i;
			scan_req_reg <= 1'b0;
			if (take && c_valid && !c_sleep)
			begin
				armed_reg  <= 1'b0;
				asleep_reg <= 1'b0;
			end
			else if (take && c_sleep)
				armed_reg <= 1'b1;
			else if (asleep_reg && int_edge)
			begin
				asleep_reg   <= 1'b0;
				scan_req_reg <= 1'b1;
			end
			// Still armed after the woken scan, so it drops back to sleep
			else if (armed_reg && scan_done_i && !key_active_i && sleep_en_i)
				asleep_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	assign tx_valid_o    = tx_valid_reg;
	assign tx_byte_o     = tx_byte_reg;
	assign busy_o        = busy_reg;
	assign key_sel_o     = key_sel_reg;
	assign setup_addr_o  = idx_reg;
	assign scan_halt_o   = halt_reg;
	assign cal_pending_o = cal_pending_reg;
	assign cal_go_o      = cal_go_reg;
	assign cal_key_o     = cal_key_reg;
	assign sleep_o       = asleep_reg;
	assign scan_req_o    = scan_req_reg;
endmodule
`default_nettype wire

/* verif/tkc_properties.sv */
// Port checker for the touch key command interpreter.
// Assumes one clock and the sync active-high reset of tkc_cmd.
`timescale 1ns/1ns
`default_nettype none
module tkc_checker (
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic       cmd_valid_i,
	input wire logic [7:0] cmd_byte_i,
	input wire logic       tx_ready_i,
	input wire logic       tx_valid_o,
	input wire logic [7:0] tx_byte_o,
	input wire logic       busy_o,
	input wire logic       scan_halt_o,
	input wire logic       slot_strobe_i,
	input wire logic [5:0] slot_key_i,
	input wire logic       cal_go_o,
	input wire logic [5:0] cal_key_o,
	input wire logic       scan_done_i,
	input wire logic       key_active_i,
	input wire logic       sleep_en_i,
	input wire logic       host_int_i,
	input wire logic       sleep_o,
	input wire logic       scan_req_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// Accepted command, and the byte before it for the echo
	wire logic  take = cmd_valid_i && !busy_o;
	logic [7:0] prev_reg;
	always_ff @(posedge clk_sys_i)
		if (cmd_valid_i)
			prev_reg <= cmd_byte_i;
	property p_tx_hold;
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("reply byte lost");
	property p_sleep_ack;
		take && cmd_byte_i == 8'h16 && !tx_valid_o
			|=> busy_o ##1 tx_valid_o && tx_byte_o == 8'hE9;
	endproperty
	a_sleep_ack: assert property (p_sleep_ack)
		else $error("bad sleep ack");
	property p_dump_halt;
		take && cmd_byte_i == 8'h0D |=> scan_halt_o;
	endproperty
	a_dump_halt: assert property (p_dump_halt)
		else $error("scan not halted");
	property p_dump_resume;
		$fell(scan_halt_o) |-> !busy_o;
	endproperty
	a_dump_resume: assert property (p_dump_resume)
		else $error("scan resumed early");
	property p_last;
		take && cmd_byte_i == 8'h0F && !tx_valid_o
			|-> ##2 tx_byte_o == $past(prev_reg, 2);
	endproperty
	a_last: assert property (p_last)
		else $error("wrong echo");
	property p_wake;
		sleep_o && $changed(host_int_i) |=> !sleep_o && scan_req_o;
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake scan");
	property p_cancel;
		sleep_o && take && cmd_byte_i == 8'h00 |=> !sleep_o;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("sleep kept");
	property p_sleep_gate;
		$rose(sleep_o) |-> $past(scan_done_i) && !$past(key_active_i)
			&& $past(sleep_en_i);
	endproperty
	a_sleep_gate: assert property (p_sleep_gate)
		else $error("slept without cause");
	property p_cal_go;
		cal_go_o |-> $past(slot_strobe_i) && $past(slot_key_i) == cal_key_o;
	endproperty
	a_cal_go: assert property (p_cal_go)
		else $error("calibration off slot");
endmodule
////////////////////////////////////////////////////////////////
bind tkc_cmd tkc_checker i_tkc_checker (.clk_sys_i, .rst_i,
	.cmd_valid_i, .cmd_byte_i, .tx_ready_i, .tx_valid_o, .tx_byte_o,
	.busy_o, .scan_halt_o, .slot_strobe_i, .slot_key_i, .cal_go_o,
	.cal_key_o, .scan_done_i, .key_active_i, .sleep_en_i, .host_int_i,
	.sleep_o, .scan_req_o);
`default_nettype wire

/* verif/tkc_host_sink.sv */
// Host model taking reply bytes from the interpreter.
// Assumes bench raises slow_i to make it stall at random.
`timescale 1ns/1ns
`default_nettype none
module tkc_host_sink (
	input  wire logic clk_sys_i,
	input  wire logic slow_i,
	output var logic  tx_ready_o
);
	integer seed = 32'h5FE3;
	initial tx_ready_o = 1'b0;
	// Random stalls so held reply bytes get exercised
	always @(negedge clk_sys_i)
		tx_ready_o <= slow_i ? 1'($random(seed)) : 1'b1;
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the touch key command interpreter.
// Assumes tkc_map.svh constants and the host sink model.
`timescale 1ns/1ns
`default_nettype none
`include "tkc_map.svh"
module tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cmd_v = 1'b0;
	logic [7:0]  cmd_b = 8'h00;
	logic        slow = 1'b0;
	logic        sstb = 1'b0;
	logic [5:0]  skey = 6'h00;
	logic        sdone = 1'b0;
	logic        kact = 1'b0;
	logic        hint = 1'b0;
	logic        sen = 1'b1;
	logic [39:0] ovw = 40'h0;
	logic [39:0] kd = 40'h0;
	logic [15:0] scrc = 16'h0;
	logic [47:0] fl [6] = '{default: 48'h0};
	logic        rdy, tx_v, busy, halt, calp, calg, slp, sreq;
	logic [7:0]  tx_b;
	logic [5:0]  ksel, calk, k;
	logic [8:0]  saddr;
	logic [7:0]  d [$];
	logic [7:0]  q [$];
	integer      seed = 32'h5FE3;
	integer      errors = 0;
	integer      n_checks = 0;
	tkc_host_sink i_tkc_host_sink (.clk_sys_i(clk), .slow_i(slow),
		.tx_ready_o(rdy));
	tkc_cmd #(.CAL_WIN_CYC(50)) i_tkc_cmd (
		.clk_sys_i(clk), .rst_i(rst), .cmd_valid_i(cmd_v),
		.cmd_byte_i(cmd_b), .tx_ready_i(rdy), .tx_valid_o(tx_v),
		.tx_byte_o(tx_b), .busy_o(busy), .dev_status_i(ovw[7:0]),
		.first_key_i(ovw[15:8]), .cnt_100ms_i(ovw[23:16]),
		.cnt_scan_i(ovw[31:24]), .cnt_sigfail_i(ovw[39:32]),
		.key_detect_i(fl[0]), .err_flags_i(fl[1]),
		.key_gain_safety_test_fail_i(fl[2]),
		.ref_below_lower_signal_limit_i(fl[3]),
		.key_calibrating_i(fl[4]), .key_cal_failed_i(fl[5]),
		.key_sel_o(ksel), .key_signal_i(kd[15:0]), .key_ref_i(kd[31:16]),
		.normalized_integrator_count_i(kd[39:32]), .setup_addr_o(saddr),
		.setup_data_i(saddr[7:0] ^ 8'hA5), .setup_crc_i(scrc),
		.scan_halt_o(halt), .slot_strobe_i(sstb), .slot_key_i(skey),
		.cal_pending_o(calp), .cal_go_o(calg), .cal_key_o(calk),
		.scan_done_i(sdone), .key_active_i(kact), .sleep_en_i(sen),
		.host_int_i(hint), .sleep_o(slp), .scan_req_o(sreq));
	initial
		forever #10 clk = ~clk;
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic complete_run;
		// Notes never met by a reply count as lost replies
		if (q.size() > 0)
		begin
			errors++;
			$display("mismatch %0t %0d replies missing", $time, q.size());
		end
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic [15:0] crc(logic [15:0] c, logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `TKC_CRC_POLY : 16'h0);
		return c;
	endfunction
	// One command byte, then wait out the reply under a bound
	task automatic send(input logic [7:0] c);
		int n;
		n = 0;
		@(negedge clk);
		cmd_v = 1'b1;
		cmd_b = c;
		@(negedge clk);
		cmd_v = 1'b0;
		@(negedge clk);
		while ((busy || tx_v || q.size() > 0) && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 2000)
		begin
			errors++;
			$display("mismatch %0t reply never ended", $time);
		end
		repeat (3) @(negedge clk);
	endtask
	// Queue the bytes in d, plus their CRC when asked
	task automatic run(input logic [7:0] c, input bit with_crc);
		logic [15:0] r;
		r = crc(`TKC_CRC_INIT, c);
		foreach (d[i])
		begin
			q.push_back(d[i]);
			r = crc(r, d[i]);
		end
		if (with_crc)
			q.push_back(r[7:0]);
		if (with_crc)
			q.push_back(r[15:8]);
		d = {};
		send(c);
	endtask
	task automatic scan_end(input logic busy_keys);
		@(negedge clk);
		kact = busy_keys;
		sdone = 1'b1;
		@(negedge clk);
		sdone = 1'b0;
	endtask
	// Monitor: every taken reply byte meets the oldest note
	always @(posedge clk)
		if (tx_v && rdy)
			chk(tx_b, q.size() > 0 ? q.pop_front() : 8'hXX);
	initial
	begin
		#400000;
		errors++;
		$display("mismatch %0t watchdog expired", $time);
		complete_run();
	end
	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		ovw = 40'({$random(seed), $random(seed)});
		kd = 40'({$random(seed), $random(seed)});
		scrc = 16'($random(seed));
		foreach (fl[i])
			fl[i] = 48'({$random(seed), $random(seed)});
		for (int i = 0; i < 5; i++)
			d.push_back(ovw[8*i+:8]);
		run(`TKC_CMD_OVW, 1);
		for (int j = 0; j < 2; j++)
		begin
			for (int i = 0; i < 6; i++)
				d.push_back(fl[j][8*i+:8]);
			run(j ? `TKC_CMD_ERR : `TKC_CMD_ALL, 1);
		end
		d.push_back(`TKC_CMD_ERR);
		run(`TKC_CMD_LAST, 0);
		for (int j = 0; j < 2; j++)
		begin
			d.push_back(`TKC_DIAG_CODE);
			run(j ? `TKC_CMD_DIAG_B : `TKC_CMD_DIAG_A, 1);
		end
		slow = 1'b1;
		for (int j = 0; j < 4; j++)
		begin
			k = j ? 6'($unsigned($random(seed)) % 48) : 6'h2F;
			for (int i = 0; i < 5; i++)
				d.push_back(kd[8*i+:8]);
			run({2'h1, k}, 1);
			chk(8'(ksel), 8'(k));
			d.push_back({3'h0, fl[2][k], fl[0][k], fl[3][k], fl[4][k],
				fl[5][k]});
			run({2'h2, k}, 1);
		end
		run(8'hB0, 0);
		for (int i = 0; i < `TKC_LEN_SETUP; i++)
			d.push_back(8'(i) ^ 8'hA5);
		d.push_back(scrc[7:0]);
		d.push_back(scrc[15:8]);
		run(`TKC_CMD_DUMP, 0);
		d.push_back(scrc[7:0]);
		d.push_back(scrc[15:8]);
		run(`TKC_CMD_EECRC, 0);
		d.push_back(8'hE9);
		run(`TKC_CMD_SLEEP, 0);
		// Busy keys must keep it awake
		scan_end(1'b1);
		chk(8'(slp), 8'h00);
		// Sleep disabled in the setups must keep it awake too
		sen = 1'b0;
		scan_end(1'b0);
		chk(8'(slp), 8'h00);
		sen = 1'b1;
		scan_end(1'b0);
		chk(8'(slp), 8'h01);
		hint = ~hint;
		@(negedge clk);
		chk(8'({slp, sreq}), 8'h01);
		scan_end(1'b0);
		chk(8'(slp), 8'h01);
		for (int i = 0; i < 5; i++)
			d.push_back(ovw[8*i+:8]);
		run(`TKC_CMD_OVW, 1);
		chk(8'(slp), 8'h00);
		run(8'hC5, 0);
		d.push_back(8'h3A);
		run(8'hC5, 0);
		chk(8'({calp, calk}), 8'h45);
		// Foreign slot first, then the key's own
		for (int i = 6; i >= 5; i--)
		begin
			sstb = 1'b1;
			skey = 6'(i);
			@(negedge clk);
			sstb = 1'b0;
			chk(8'(calg), 8'(i == 5));
			@(negedge clk);
		end
		// A repeat after the window counts as a new first byte
		run(8'hC7, 0);
		repeat (60) @(negedge clk);
		run(8'hC7, 0);
		chk(8'(calp), 8'h00);
		d.push_back(8'h38);
		run(8'hC7, 0);
		chk(8'({calp, calk}), 8'h47);
		repeat (5) @(negedge clk);
		complete_run();
	end
endmodule
`default_nettype wire
